// ===== pkg/gpp_pkg.sv
package gpp_pkg;
   // register byte addresses
   localparam logic [31:0] P0_DATA_ADDR = 32'hFFFF0D20;
   localparam logic [31:0] P0_SET_ADDR = 32'hFFFF0D24;
   localparam logic [31:0] P2_DATA_ADDR = 32'hFFFF0D40;
   localparam logic [31:0] HV_CFG_ADDR = 32'hFFFF0D60;

   // port-two field layout, entry i is the pin position of index i
   localparam int P2_PINS = 5;
   localparam int P2_POS [P2_PINS] = '{0, 1, 4, 5, 6};
   localparam int P2_DIR_BASE = 24;
   localparam int P2_OUT_BASE = 16;
   localparam int P2_IN_BASE = 0;
   // positions that own an output bit (position 4 has none)
   localparam logic [4:0] P2_OUT_CAP = 5'h1B;
   localparam int P2_HV_WR_IDX = 3;
   localparam int P2_HV_RD_IDX = 2;

   // port-zero field layout
   localparam int P0_PINS = 5;
   localparam int P0_OUT_BASE = 16;

   // high-voltage diagnostic select field
   localparam int HV_SEL_LSB = 0;
   localparam int HV_SEL_W = 3;

   // values after reset
   localparam logic [4:0] P2_DIR_RST = 5'h00;
   localparam logic [4:0] P2_OUT_RST = 5'h00;
   localparam logic [4:0] P0_OUT_RST = 5'h00;
   localparam logic [2:0] HV_SEL_RST = 3'h0;
   localparam logic [31:0] HRDATA_RST = 32'h0000_0000;

   // bus encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;
endpackage

// ===== src/gpp_sync.sv
`timescale 1ns/1ps
module gpp_sync #(
   parameter int WIDTH = 5
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   // asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_one;

   // two flops; only the second reads the first
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         stage_one <= '0;
         sync_out <= '0;
      end else begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end
endmodule

// ===== src/gpp_ahb_slave.sv
`timescale 1ns/1ps
module gpp_ahb_slave
   import gpp_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   // ahb-lite slave side
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hready_in,
   output logic hreadyout_out,
   output logic hresp_out,
   // address-phase read strobes
   output logic rd_p0_out,
   output logic rd_p2_out,
   output logic rd_hv_out,
   // data-phase write strobes
   output logic wr_p0_set_out,
   output logic wr_p2_out,
   output logic wr_hv_out
);
   logic take;
   logic wr_p0_set;
   logic wr_p2;
   logic wr_hv;

   // transfer accepted on nonseq or seq with ready high, word size only
   assign take = hsel_in && hready_in && htrans_in[1] && (hsize_in == HSIZE_WORD);

   // reads are answered from the address phase
   assign rd_p0_out = take && !hwrite_in && (haddr_in == P0_DATA_ADDR);
   assign rd_p2_out = take && !hwrite_in && (haddr_in == P2_DATA_ADDR);
   assign rd_hv_out = take && !hwrite_in && (haddr_in == HV_CFG_ADDR);

   // write targets latched for the data phase
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         wr_p0_set <= 1'b0;
         wr_p2 <= 1'b0;
         wr_hv <= 1'b0;
      end else if (hready_in) begin
         wr_p0_set <= take && hwrite_in && (haddr_in == P0_SET_ADDR);
         wr_p2 <= take && hwrite_in && (haddr_in == P2_DATA_ADDR);
         wr_hv <= take && hwrite_in && (haddr_in == HV_CFG_ADDR);
      end
   end

   // zero wait states, always okay
   assign wr_p0_set_out = wr_p0_set;
   assign wr_p2_out = wr_p2;
   assign wr_hv_out = wr_hv;
   assign hreadyout_out = 1'b1;
   assign hresp_out = HRESP_OKAY;
endmodule

// ===== src/gpp_top.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module gpp_top
   import gpp_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   // ahb-lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // port-two pads, index order positions 0, 1, 4, 5, 6
   input wire logic [4:0] p2_pad_in,
   output logic [4:0] p2_pad_out,
   output logic [4:0] p2_pad_oe_out,
   // port-zero pads, positions 0 to 4
   output logic [4:0] p0_pad_out,
   // high-voltage diagnostic path
   output logic hv_diag_wr_out,
   output logic hv_diag_rd_en_out,
   output logic [2:0] hv_diag_sel_out
);
   logic rd_p0;
   logic rd_p2;
   logic rd_hv;
   logic wr_p0_set;
   logic wr_p2;
   logic wr_hv;
   logic [4:0] p2_sync;
   logic [4:0] p2_dir;
   logic [4:0] p2_out;
   logic [4:0] p0_out;
   logic [2:0] hv_sel;
   logic [4:0] next_p2_dir;
   logic [4:0] next_p2_out;
   logic [4:0] next_p0_out;
   logic [2:0] next_hv_sel;
   logic [31:0] p2_word;
   logic [31:0] p0_word;
   logic [31:0] hv_word;
   logic [31:0] hrdata;

   // bus front end
   gpp_ahb_slave u_bus (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .hsel_in(hsel_in),
      .haddr_in(haddr_in),
      .htrans_in(htrans_in),
      .hwrite_in(hwrite_in),
      .hsize_in(hsize_in),
      .hready_in(hready_in),
      .hreadyout_out(hreadyout_out),
      .hresp_out(hresp_out),
      .rd_p0_out(rd_p0),
      .rd_p2_out(rd_p2),
      .rd_hv_out(rd_hv),
      .wr_p0_set_out(wr_p0_set),
      .wr_p2_out(wr_p2),
      .wr_hv_out(wr_hv)
   );

   // pad levels come from outside the clock domain
   gpp_sync #(.WIDTH(P2_PINS)) u_sync (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .async_in(p2_pad_in),
      .sync_out(p2_sync)
   );

   // per-pin next state, pad drive and read word for port two
   genvar gi;
   generate
      for (gi = 0; gi < P2_PINS; gi++) begin : g_p2
         assign next_p2_dir[gi] = wr_p2 ? hwdata_in[P2_DIR_BASE + P2_POS[gi]] : p2_dir[gi];
         // output value, only where an output bit exists
         assign next_p2_out[gi] = wr_p2 ?
            (hwdata_in[P2_OUT_BASE + P2_POS[gi]] & P2_OUT_CAP[gi]) : p2_out[gi];
         // value reaches the pad only while an output
         assign p2_pad_out[gi] = p2_out[gi] & p2_dir[gi];
         assign p2_pad_oe_out[gi] = p2_dir[gi];
         assign p2_word[P2_DIR_BASE + P2_POS[gi]] = next_p2_dir[gi];
         assign p2_word[P2_OUT_BASE + P2_POS[gi]] = next_p2_out[gi] & P2_OUT_CAP[gi];
         // pin-input bits show the synchronised level
         assign p2_word[P2_IN_BASE + P2_POS[gi]] = p2_sync[gi];
      end
   endgenerate

   // reserved port-two bits read as zero
   assign p2_word[31] = 1'b0;
   assign p2_word[27:26] = 2'h0;
   assign p2_word[23] = 1'b0;
   // bit 20 is the missing position-4 output, driven zero by the loop
   assign p2_word[19:18] = 2'h0;
   assign p2_word[15:7] = 9'h000;
   assign p2_word[3:2] = 2'h0;

   // set register ors into the held port-zero value only
   assign next_p0_out = wr_p0_set ?
      (p0_out | hwdata_in[P0_OUT_BASE +: P0_PINS]) : p0_out;
   // readback view of the port-zero output bits
   assign p0_word = {11'h000, next_p0_out, 16'h0000};

   // diagnostic select field
   assign next_hv_sel = wr_hv ? hwdata_in[HV_SEL_LSB +: HV_SEL_W] : hv_sel;
   assign hv_word = {29'h0000_0000, next_hv_sel};

   // register state, one process per concern
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         p2_dir <= P2_DIR_RST;
         p2_out <= P2_OUT_RST;
      end else begin
         p2_dir <= next_p2_dir;
         p2_out <= next_p2_out;
      end
   end

   // port-zero held outputs
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         p0_out <= P0_OUT_RST;
      end else begin
         p0_out <= next_p0_out;
      end
   end

   // diagnostic select
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         hv_sel <= HV_SEL_RST;
      end else begin
         hv_sel <= next_hv_sel;
      end
   end

   // read mux; next values forward a write in its data phase
   always_comb begin
      hrdata = 32'h0000_0000;
      if (rd_p2) begin
         hrdata = p2_word;
      end else if (rd_p0) begin
         hrdata = p0_word;
      end else if (rd_hv) begin
         hrdata = hv_word;
      end
   end

   // read data captured at the address phase, stands through data phase
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         hrdata_out <= HRDATA_RST;
      end else if (rd_p0 || rd_p2 || rd_hv) begin
         hrdata_out <= hrdata;
      end
   end

   assign p0_pad_out = p0_out;

   // position 5 output feeds the diagnostic write path
   assign hv_diag_wr_out = p2_dir[P2_HV_WR_IDX] & p2_out[P2_HV_WR_IDX];
   // position 4 input with a nonzero select enables readback
   assign hv_diag_rd_en_out = !p2_dir[P2_HV_RD_IDX] && (hv_sel != 3'h0);
   assign hv_diag_sel_out = hv_sel;

   // checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);

   chk_dir_sets_oe:
   assert property ((wr_p2 && hwdata_in[30]) |=> p2_pad_oe_out[4])
      else $error("direction bit 30 did not enable position 6 driver");

   chk_dir_clears_oe:
   assert property ((wr_p2 && !hwdata_in[24]) |=> !p2_pad_oe_out[0] && !p2_pad_out[0])
      else $error("direction bit 24 clear did not release position 0");

   chk_hv_write_path:
   assert property ((wr_p2 && hwdata_in[29] && hwdata_in[21]) |=> hv_diag_wr_out)
      else $error("diagnostic write path not driven from position 5");

   chk_hv_read_path:
   assert property ((wr_hv && hwdata_in[2:0] != 3'h0 && !next_p2_dir[2])
      |=> hv_diag_rd_en_out && hv_diag_sel_out == $past(hwdata_in[2:0]))
      else $error("diagnostic readback not enabled by select");

   chk_out_to_pad:
   assert property ((wr_p2 && hwdata_in[30] && hwdata_in[22])
      |=> p2_pad_out[4] ##1 (p2_pad_out[4] || $past(wr_p2)))
      else $error("output bit 22 not driven on position 6");

   chk_pin_readback:
   assert property (rd_p2 |=> hrdata_out[6] == $past(p2_sync[4]) && hrdata_out[0] == $past(p2_sync[0]))
      else $error("pin-input bits do not match pad levels");

   chk_drive_gated:
   assert property ((p2_pad_out & ~p2_pad_oe_out) == 5'h00)
      else $error("pad driven while configured as input");

   chk_set_drives_high:
   assert property ((wr_p0_set && hwdata_in[16]) |=> p0_pad_out[0])
      else $error("set bit 16 did not drive port-zero pin 0 high");

   chk_set_zero_keeps:
   assert property (wr_p0_set |=> ((p0_pad_out ^ $past(p0_pad_out)) & ~$past(hwdata_in[20:16])) == 5'h00)
      else $error("set register zero changed a pin");

   chk_set_isolated:
   assert property ((wr_p0_set && !wr_p2) |=> $stable(p2_pad_oe_out) && $stable(p2_pad_out))
      else $error("set register disturbed port two");

   chk_set_readback:
   assert property ((wr_p0_set && hwdata_in[18]) ##[1:4] rd_p0 |=> hrdata_out[18])
      else $error("set bit not visible on port-zero readback");

   chk_set_all_high:
   assert property (wr_p0_set
      |=> (p0_pad_out & $past(hwdata_in[20:16])) == $past(hwdata_in[20:16]))
      else $error("a set bit left its port-zero pin low");

   chk_p0_held:
   assert property (!wr_p0_set |=> $stable(p0_pad_out))
      else $error("port-zero pins moved without a set write");

   chk_p0_no_fall:
   assert property ((~p0_pad_out & $past(p0_pad_out)) == 5'h00)
      else $error("a stored port-zero output fell without reset");

   chk_p0_readback:
   assert property (rd_p0 |=> hrdata_out == {11'h000, p0_pad_out, 16'h0000})
      else $error("port-zero readback differs from the pin levels");

   chk_p2_held:
   assert property (!wr_p2 |=> $stable(p2_pad_oe_out) && $stable(p2_pad_out))
      else $error("port-two pads moved without a data write");

   // reserved and missing-output bits must never read as one
   chk_p2_rsvd_zero:
   assert property (rd_p2 |=> (hrdata_out & 32'h8C9C_FF8C) == 32'h0000_0000)
      else $error("reserved port-two bit read as one");

   chk_hv_sel_load:
   assert property (wr_hv |=> hv_diag_sel_out == $past(hwdata_in[2:0]))
      else $error("diagnostic select not loaded from write data");

   chk_hv_readback:
   assert property (rd_hv |=> hrdata_out == {29'h0000_0000, hv_diag_sel_out})
      else $error("diagnostic select readback differs");

   chk_hv_rd_gate:
   assert property (hv_diag_rd_en_out |-> !p2_pad_oe_out[2] && hv_diag_sel_out != 3'h0)
      else $error("readback enabled while position 4 drives or select is off");

   chk_hv_wr_gate:
   assert property (hv_diag_wr_out |-> p2_pad_oe_out[3])
      else $error("diagnostic write active while position 5 is an input");

   // per-pin checks of direction, drive and readback
   genvar gc;
   generate
      for (gc = 0; gc < P2_PINS; gc++) begin : g_chk
         chk_pin_dir_lands:
         assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
            wr_p2 |=> p2_pad_oe_out[gc] == $past(hwdata_in[P2_DIR_BASE + P2_POS[gc]]))
            else $error("direction write did not reach the pad enable");

         chk_pin_value_lands:
         assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
            wr_p2 |=> p2_pad_out[gc] == (P2_OUT_CAP[gc]
            && $past(hwdata_in[P2_DIR_BASE + P2_POS[gc]])
            && $past(hwdata_in[P2_OUT_BASE + P2_POS[gc]])))
            else $error("output write did not reach the pad");

         chk_pin_released:
         assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
            !p2_pad_oe_out[gc] |-> !p2_pad_out[gc])
            else $error("released pad still shows a drive value");

         chk_pin_level_read:
         assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
            rd_p2 |=> hrdata_out[P2_IN_BASE + P2_POS[gc]] == $past(p2_sync[gc]))
            else $error("pin-input bit does not show the pad level");

         chk_pin_dir_read:
         assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
            rd_p2 |=> hrdata_out[P2_DIR_BASE + P2_POS[gc]] == p2_pad_oe_out[gc])
            else $error("direction bit readback differs from the pad enable");
      end
   endgenerate
endmodule

// ===== tb/gpp_pad_model.sv
`timescale 1ns/1ps
// pad wires of port two: device driver, outside driver, else floating
module gpp_pad_model (
   // clock
   input wire logic ref_clk_in,
   // device side
   input wire logic [4:0] pad_out_in,
   input wire logic [4:0] pad_oe_in,
   // outside world
   input wire logic [4:0] ext_level_in,
   input wire logic [4:0] ext_drive_in,
   // resolved pad levels
   output logic [4:0] pad_level_out
);
   logic [4:0] float_q = 5'h0A;
   // no pulls: a floating pad wanders every cycle
   always_ff @(posedge ref_clk_in) begin
      float_q <= ~float_q;
   end
   // both drivers at once means contention
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         case ({pad_oe_in[i], ext_drive_in[i]})
            2'h2: pad_level_out[i] = pad_out_in[i];
            2'h1: pad_level_out[i] = ext_level_in[i];
            2'h3: pad_level_out[i] = 1'bx;
            default: pad_level_out[i] = float_q[i];
         endcase
      end
   end
endmodule

// ===== tb/gpp_port2_data_port0_set_bench.sv
`timescale 1ns/1ps
module gpp_port2_data_port0_set_bench;
   import gpp_pkg::*;
   // clock, reset and bus master drives
   logic ref_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [4:0] ext_level = 5'h00;
   // design outputs and pad wires
   logic [31:0] hrdata;
   logic hreadyout, hresp, hv_wr, hv_rd_en;
   logic [4:0] pad_in, pad_out, pad_oe, p0_pad, ext_drive;
   logic [2:0] hv_sel;
   logic [31:0] rd;
   int errors = 0;
   int total_checks = 0;

   // the outside world drives every pin the device leaves as input
   assign ext_drive = ~pad_oe;

   initial begin
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   gpp_top dut_u (
      .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
      .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
      .hresp_out(hresp), .p2_pad_in(pad_in), .p2_pad_out(pad_out), .p2_pad_oe_out(pad_oe),
      .p0_pad_out(p0_pad), .hv_diag_wr_out(hv_wr), .hv_diag_rd_en_out(hv_rd_en),
      .hv_diag_sel_out(hv_sel)
   );

   gpp_pad_model pads_u (
      .ref_clk_in(ref_clk_in), .pad_out_in(pad_out), .pad_oe_in(pad_oe),
      .ext_level_in(ext_level), .ext_drive_in(ext_drive), .pad_level_out(pad_in)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // wait for hready under a bound
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         errors++;
         $display("unexpected at %0t: bus hang", $time);
         summarize();
      end
   endtask

   // one single-word transfer; read data lands in rd
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
      check(hresp, HRESP_OKAY);
      #1;
   endtask

   initial begin
      repeat (6) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      #1;
      check(pad_oe, P2_DIR_RST);
      check(p0_pad, P0_OUT_RST);
      xfer(1'b0, P2_DATA_ADDR, 32'h0);
      check(rd, 32'h0);
      $display("test reset done");
      // one direction bit at a time, all output values set
      for (int i = 0; i < P2_PINS; i++) begin
         xfer(1'b1, P2_DATA_ADDR, (32'h1 << (P2_DIR_BASE + P2_POS[i])) | 32'h00630000);
         check(pad_oe, 5'h01 << i);
         check(pad_out, (5'h01 << i) & P2_OUT_CAP);
         check(hv_wr, 32'(i == P2_HV_WR_IDX));
      end
      xfer(1'b1, P2_DATA_ADDR, 32'h73630000);
      repeat (3) @(posedge ref_clk_in);
      xfer(1'b0, P2_DATA_ADDR, 32'h0);
      check(rd, 32'h73630063);
      $display("test directions done");
      ext_level <= 5'h15;
      xfer(1'b1, P2_DATA_ADDR, 32'h00630000);
      check(pad_oe, 5'h00);
      check(pad_out, 5'h00);
      repeat (3) @(posedge ref_clk_in);
      xfer(1'b0, P2_DATA_ADDR, 32'h0);
      check(rd, 32'h00630051);
      $display("test inputs done");
      xfer(1'b1, HV_CFG_ADDR, 32'h5);
      check(hv_rd_en, 1'b1);
      check(hv_sel, 3'h5);
      xfer(1'b1, P2_DATA_ADDR, 32'h10000000);
      check(hv_rd_en, 1'b0);
      xfer(1'b0, HV_CFG_ADDR, 32'h0);
      check(rd, 32'h5);
      $display("test diagnostics done");
      xfer(1'b1, P0_SET_ADDR, 32'h00050000);
      check(p0_pad, 5'h05);
      xfer(1'b1, P0_SET_ADDR, 32'h00120000);
      check(p0_pad, 5'h17);
      xfer(1'b1, P0_SET_ADDR, 32'h0);
      check(p0_pad, 5'h17);
      xfer(1'b0, P0_DATA_ADDR, 32'h0);
      check(rd, 32'h00170000);
      xfer(1'b0, 32'hFFFF0D50, 32'h0);
      check(rd, 32'h00170000);
      xfer(1'b1, P0_SET_ADDR, 32'h001F0000);
      check(p0_pad, 5'h1F);
      xfer(1'b0, P0_DATA_ADDR, 32'h0);
      check(rd, 32'h001F0000);
      xfer(1'b1, P0_DATA_ADDR, 32'h0);
      check(p0_pad, 5'h1F);
      xfer(1'b0, P0_SET_ADDR, 32'h0);
      check(rd, 32'h001F0000);
      $display("test set register done");
      summarize();
   end
endmodule
